//--- core/dss_defs.vh
// constants for the dual card serial control block
//
// Contract
// - each serial transfer carries exactly eight bits; other lengths are dropped
// - serial port is write only; nothing is ever driven back
// - first three bits are register address, last five are data
// - address 0: reset source select in 1:0, forced value in 3:2, reset zero
// - lower bit of each field is channel one, upper bit channel two
// - powered channel: select 0 follows host reset, 1 follows forced value
// - forced reset value acts only when powered and source select is 1
// - address 1: phase bits 3:2, polarity bits 1:0, reset polarity 11 phase 00
// - powered channel: pair 01 passes host clock, 11 stops high, 00 low
// - address 2: force low bits 3:2, data path enable 1:0, reset zero
// - powered channel: path enable 0 isolates card and host data lines, both left undriven
// - powered channel: path enable 1 with force low 0 joins card and host data lines both ways
// - powered and enabled, force low 1 holds card data at 0
// - power enable 0 drives all card signals 0; 1 turns supply on (card_volt_sel still follows voltage select while power enable is 0)
// - address 3: voltage select 1:0 (0 low, 1 high), power enable 3:2
`ifndef DSS_DEFS_VH
`define DSS_DEFS_VH
`define DSS_WORD_BITS 8
`define DSS_ADDR_RESET 3'h0
`define DSS_ADDR_CLOCK 3'h1
`define DSS_ADDR_DATA 3'h2
`define DSS_ADDR_POWER 3'h3
`define DSS_RST_RESET 4'h0
`define DSS_CLK_RESET 4'h3
`define DSS_DAT_RESET 4'h0
`define DSS_PWR_RESET 4'h0
`define DSS_LO_FIELD 1:0
`define DSS_HI_FIELD 3:2
`define DSS_GUARD_CYCLES 2'h3
`define DSS_OWN_IDLE 2'h0
`define DSS_OWN_HOST 2'h1
`define DSS_OWN_CARD 2'h2
`define DSS_OWN_GUARD 2'h3
`endif

//--- core/dss_top.v
// serial control receiver, register set and per channel card signal logic
`timescale 1ns/1ps
`include "dss_defs.vh"
module dss_top
(
    input wire clk_sys,
    input wire rst_n,
    input wire ser_clk_in,
    input wire ser_data_in,
    input wire ser_sel_n,
    input wire host_reset_in,
    input wire host_clock_in,
    input wire [1:0] host_data_in,
    output reg [1:0] host_data_out,
    output reg [1:0] host_data_oe,
    input wire [1:0] card_data_in,
    output reg [1:0] card_data_out,
    output reg [1:0] card_data_oe,
    output reg [1:0] card_reset_out,
    output reg [1:0] card_clock_out,
    output reg [1:0] card_power_en,
    output reg [1:0] card_volt_sel
);
    // two stage synchronisers; stage one feeds stage two only
    reg [4:0] meta_q;
    reg [4:0] sync_q;
    reg [1:0] hd_meta_q;
    reg [1:0] hd_sync_q;
    reg [1:0] cd_meta_q;
    reg [1:0] cd_sync_q;
    reg sck_prev_q;
    reg sel_prev_q;
    reg [7:0] shift_q;
    reg [3:0] cnt_q;
    reg [3:0] rst_ctl_q;
    reg [3:0] clk_ctl_q;
    reg [3:0] dat_ctl_q;
    reg [3:0] pwr_ctl_q;
    wire s_clk;
    wire s_data;
    wire s_sel_n;
    wire s_hrst;
    wire s_hclk;
    wire sck_rise;
    wire sel_rise;
    wire [1:0] reset_src_sel;
    wire [1:0] reset_force_val;
    wire [1:0] clk_phase_bit;
    wire [1:0] clk_polarity_bit;
    wire [1:0] data_path_en;
    wire [1:0] data_force_low;
    wire [1:0] pwr_en;
    wire [1:0] volt_sel;

    assign s_clk = sync_q[0];
    assign s_data = sync_q[1];
    assign s_sel_n = sync_q[2];
    assign s_hrst = sync_q[3];
    assign s_hclk = sync_q[4];
    assign sck_rise = s_clk & ~sck_prev_q;
    assign sel_rise = s_sel_n & ~sel_prev_q;

    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            meta_q <= 5'h1c;
            sync_q <= 5'h1c;
            hd_meta_q <= 2'h3;
            hd_sync_q <= 2'h3;
            cd_meta_q <= 2'h3;
            cd_sync_q <= 2'h3;
            sck_prev_q <= 1'b0;
            sel_prev_q <= 1'b1;
        end
        else
        begin
            meta_q <= {host_clock_in, host_reset_in, ser_sel_n, ser_data_in, ser_clk_in};
            sync_q <= meta_q;
            hd_meta_q <= host_data_in;
            hd_sync_q <= hd_meta_q;
            cd_meta_q <= card_data_in;
            cd_sync_q <= cd_meta_q;
            sck_prev_q <= s_clk;
            sel_prev_q <= s_sel_n;
        end
    end

    // bit counter saturates at nine so an over-long word is never taken
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            shift_q <= 8'h00;
            cnt_q <= 4'h0;
        end
        else if (s_sel_n)
        begin
            cnt_q <= 4'h0;
        end
        else if (sck_rise)
        begin
            shift_q <= {shift_q[6:0], s_data};
            if (cnt_q != 4'h9)
            begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    // write only: registers are never presented back on a pin
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rst_ctl_q <= `DSS_RST_RESET;
            clk_ctl_q <= `DSS_CLK_RESET;
            dat_ctl_q <= `DSS_DAT_RESET;
            pwr_ctl_q <= `DSS_PWR_RESET;
        end
        else if (sel_rise && cnt_q == `DSS_WORD_BITS)
        begin
            // address in 7:5, data bit four dropped
            case (shift_q[7:5])
                `DSS_ADDR_RESET: rst_ctl_q <= shift_q[3:0];
                `DSS_ADDR_CLOCK: clk_ctl_q <= shift_q[3:0];
                `DSS_ADDR_DATA: dat_ctl_q <= shift_q[3:0];
                `DSS_ADDR_POWER: pwr_ctl_q <= shift_q[3:0];
                default: pwr_ctl_q <= pwr_ctl_q;
            endcase
        end
    end

    assign reset_src_sel = rst_ctl_q[`DSS_LO_FIELD];
    assign reset_force_val = rst_ctl_q[`DSS_HI_FIELD];
    assign clk_polarity_bit = clk_ctl_q[`DSS_LO_FIELD];
    assign clk_phase_bit = clk_ctl_q[`DSS_HI_FIELD];
    assign data_path_en = dat_ctl_q[`DSS_LO_FIELD];
    assign data_force_low = dat_ctl_q[`DSS_HI_FIELD];
    assign volt_sel = pwr_ctl_q[`DSS_LO_FIELD];
    assign pwr_en = pwr_ctl_q[`DSS_HI_FIELD];

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : g_ch
            reg [1:0] own_q;
            reg [1:0] guard_q;
            // clock passes through the synchroniser, so it lags by about three cycles
            always @(posedge clk_sys)
            begin
                if (!rst_n)
                begin
                    card_reset_out[ch] <= 1'b0;
                    card_clock_out[ch] <= 1'b0;
                    card_power_en[ch] <= 1'b0;
                    card_volt_sel[ch] <= 1'b0;
                end
                else
                begin
                    card_power_en[ch] <= pwr_en[ch];
                    card_volt_sel[ch] <= volt_sel[ch];
                    if (!pwr_en[ch])
                    begin
                        card_reset_out[ch] <= 1'b0;
                        card_clock_out[ch] <= 1'b0;
                    end
                    else
                    begin
                        card_reset_out[ch] <= reset_src_sel[ch] ?
                            reset_force_val[ch] : s_hrst;
                        // the forbidden pair 10 is parked low
                        case ({clk_phase_bit[ch], clk_polarity_bit[ch]})
                            2'h1: card_clock_out[ch] <= s_hclk;
                            2'h3: card_clock_out[ch] <= 1'b1;
                            default: card_clock_out[ch] <= 1'b0;
                        endcase
                    end
                end
            end

            // one side owns the link at a time; the guard hides our own released low
            always @(posedge clk_sys)
            begin
                if (!rst_n)
                begin
                    own_q <= `DSS_OWN_IDLE;
                    guard_q <= 2'h0;
                end
                else if (!pwr_en[ch] || !data_path_en[ch] || data_force_low[ch])
                begin
                    own_q <= `DSS_OWN_IDLE;
                    guard_q <= 2'h0;
                end
                else
                begin
                    case (own_q)
                        `DSS_OWN_IDLE:
                        begin
                            if (!hd_sync_q[ch])
                            begin
                                own_q <= `DSS_OWN_HOST;
                            end
                            else if (!cd_sync_q[ch])
                            begin
                                own_q <= `DSS_OWN_CARD;
                            end
                        end
                        `DSS_OWN_HOST:
                        begin
                            if (hd_sync_q[ch])
                            begin
                                own_q <= `DSS_OWN_GUARD;
                                guard_q <= `DSS_GUARD_CYCLES;
                            end
                        end
                        `DSS_OWN_CARD:
                        begin
                            if (cd_sync_q[ch])
                            begin
                                own_q <= `DSS_OWN_GUARD;
                                guard_q <= `DSS_GUARD_CYCLES;
                            end
                        end
                        `DSS_OWN_GUARD:
                        begin
                            if (guard_q == 2'h0)
                            begin
                                own_q <= `DSS_OWN_IDLE;
                            end
                            else
                            begin
                                guard_q <= guard_q - 2'h1;
                            end
                        end
                        default: own_q <= `DSS_OWN_IDLE;
                    endcase
                end
            end

            // open drain style: out is always 0, only the enables move
            always @(posedge clk_sys)
            begin
                if (!rst_n)
                begin
                    card_data_out[ch] <= 1'b0;
                    card_data_oe[ch] <= 1'b1;
                    host_data_out[ch] <= 1'b0;
                    host_data_oe[ch] <= 1'b0;
                end
                else
                begin
                    card_data_out[ch] <= 1'b0;
                    host_data_out[ch] <= 1'b0;
                    if (!pwr_en[ch])
                    begin
                        card_data_oe[ch] <= 1'b1;
                        host_data_oe[ch] <= 1'b0;
                    end
                    else if (!data_path_en[ch])
                    begin
                        card_data_oe[ch] <= 1'b0;
                        host_data_oe[ch] <= 1'b0;
                    end
                    else if (data_force_low[ch])
                    begin
                        card_data_oe[ch] <= 1'b1;
                        host_data_oe[ch] <= 1'b0;
                    end
                    else
                    begin
                        card_data_oe[ch] <= own_q == `DSS_OWN_HOST && !hd_sync_q[ch];
                        host_data_oe[ch] <= own_q == `DSS_OWN_CARD && !cd_sync_q[ch];
                    end
                end
            end
        end
    endgenerate
endmodule // dss_top

//--- test/dss_top_asserts.sv
// port checker for the dual card serial control block
`timescale 1ns/1ps
module dss_asserts
(
    input wire clk_sys,
    input wire rst_n,
    input wire ser_sel_n,
    input wire [1:0] host_data_out,
    input wire [1:0] host_data_oe,
    input wire [1:0] card_data_out,
    input wire [1:0] card_data_oe,
    input wire [1:0] card_reset_out,
    input wire [1:0] card_clock_out,
    input wire [1:0] card_power_en,
    input wire [1:0] card_volt_sel
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // off for two cycles, so the output flop has caught up
    AST_OFF_RST: assert property (!card_power_en[0] && !$past(card_power_en[0])
        |-> !card_reset_out[0]) else $error("card reset high while unpowered");
    AST_OFF_CLK: assert property (!card_power_en[1] && !$past(card_power_en[1])
        |-> !card_clock_out[1]) else $error("card clock high while unpowered");
    AST_OFF_DATA: assert property (!card_power_en[0] && !$past(card_power_en[0])
        |-> card_data_oe[0] && !host_data_oe[0]) else $error("unpowered data line wrong");
    AST_NO_DRIVE_HIGH: assert property (card_data_out == 2'h0 && host_data_out == 2'h0)
        else $error("data line driven high");
    AST_HOLD_WHILE_SEL: assert property ((!ser_sel_n)[*8]
        |-> $stable(card_power_en) && $stable(card_volt_sel)) else $error("update mid word");
    AST_NO_EARLY_COMMIT: assert property ($rose(ser_sel_n)
        |-> ($stable(card_power_en) && $stable(card_volt_sel))[*3]) else $error("early commit");
    AST_RESET_STATE: assert property (disable iff (1'b0) !rst_n
        |=> card_power_en == 2'h0 && card_data_oe == 2'h3) else $error("bad reset state");
    AST_CLK_NEEDS_PWR: assert property ($rose(card_clock_out[1])
        |-> card_power_en[1] || $past(card_power_en[1])) else $error("clock while unpowered");
    cover property ($rose(card_power_en[0]));
    cover property ($rose(card_clock_out[0]));
    cover property ($rose(card_data_oe[0]) && card_power_en[0]);
endmodule // dss_asserts

bind dss_top dss_asserts dss_asserts_inst (.clk_sys, .rst_n, .ser_sel_n, .host_data_out,
    .host_data_oe, .card_data_out, .card_data_oe, .card_reset_out, .card_clock_out,
    .card_power_en, .card_volt_sel);

//--- test/dss_bb_model.sv
// baseband side model driving the serial control lines
`timescale 1ns/1ps
module dss_bb_model
(
    input wire clk_sys,
    output reg ser_clk_in,
    output reg ser_data_in,
    output reg ser_sel_n
);
    integer i;
    initial
    begin
        ser_clk_in = 1'b0;
        ser_data_in = 1'b0;
        ser_sel_n = 1'b1;
    end
    // n below eight only to provoke a refusal
    task send(input [7:0] w, input integer n);
        begin
            @(negedge clk_sys);
            ser_sel_n = 1'b0;
            for (i = 0; i < n; i = i + 1)
            begin
                ser_data_in = w[7 - i];
                repeat (4) @(negedge clk_sys);
                ser_clk_in = 1'b1;
                repeat (4) @(negedge clk_sys);
                ser_clk_in = 1'b0;
            end
            repeat (4) @(negedge clk_sys);
            ser_sel_n = 1'b1;
            // idle data is not held, so show a changed level
            ser_data_in = ~ser_data_in;
        end
    endtask
endmodule // dss_bb_model

//--- test/dss_top_tb.sv
// testbench for the dual card serial control block
`timescale 1ns/1ps
module dss_top_tb;
    reg clk_sys;
    reg rst_n;
    reg host_reset_in;
    reg host_clock_in;
    reg [1:0] host_drv_n;
    reg [1:0] card_drv_n;
    wire ser_clk_in;
    wire ser_data_in;
    wire ser_sel_n;
    wire [1:0] host_data_out, host_data_oe, card_data_out, card_data_oe;
    wire [1:0] card_reset_out, card_clock_out, card_power_en, card_volt_sel;
    // both data lines pulled up; host and card each may pull low
    wire [1:0] host_data_in = host_drv_n & ~host_data_oe;
    wire [1:0] card_data_in = card_drv_n & ~card_data_oe;
    integer err_count = 0;
    integer n_compared = 0;
    integer cyc = 0;
    dss_bb_model dss_bb_model_inst (.clk_sys, .ser_clk_in, .ser_data_in, .ser_sel_n);
    dss_top dss_top_inst (.clk_sys, .rst_n, .ser_clk_in, .ser_data_in, .ser_sel_n,
        .host_reset_in, .host_clock_in, .host_data_in, .host_data_out, .host_data_oe,
        .card_data_in, .card_data_out, .card_data_oe, .card_reset_out, .card_clock_out,
        .card_power_en, .card_volt_sel);
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task check(input [1:0] seen, input [1:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp)
            begin
                err_count = err_count + 1;
                $display("FAIL %0t seen %b expected %b", $time, seen, exp);
            end
        end
    endtask
    task wr(input [7:0] w, input integer n);
        begin
            dss_bb_model_inst.send(w, n);
            repeat (10) @(negedge clk_sys);
        end
    endtask
    task summarize;
        begin
            $display("compared %0d mismatches %0d", n_compared, err_count);
            if (err_count == 0 && n_compared > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_count = err_count + 1;
            summarize;
        end
    end
    initial
    begin
        rst_n = 1'b0;
        host_reset_in = 1'b0;
        host_clock_in = 1'b0;
        host_drv_n = 2'h3;
        card_drv_n = 2'h3;
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        check(card_power_en, 2'h0);
        check(card_data_oe, 2'h3);
        check(card_reset_out | card_clock_out, 2'h0);
        $display("test reset state done");
        wr(8'h6d, 8);
        check(card_power_en, 2'h3);
        check(card_volt_sel, 2'h1);
        check(card_clock_out, 2'h0);
        check(card_data_oe | host_data_oe, 2'h0);
        host_reset_in = 1'b1;
        host_clock_in = 1'b1;
        repeat (6) @(negedge clk_sys);
        check(card_reset_out, 2'h3);
        check(card_clock_out, 2'h3);
        host_clock_in = 1'b0;
        $display("test power on done");
        wr(8'h17, 8);
        check(card_reset_out, 2'h1);
        wr(8'h21, 8);
        host_clock_in = 1'b1;
        repeat (6) @(negedge clk_sys);
        check(card_clock_out, 2'h1);
        host_clock_in = 1'b0;
        repeat (6) @(negedge clk_sys);
        check(card_clock_out, 2'h0);
        wr(8'h2b, 8);
        check(card_clock_out, 2'h2);
        $display("test reset and clock done");
        wr(8'h4b, 8);
        check(card_data_oe, 2'h2);
        host_drv_n = 2'h2;
        repeat (8) @(negedge clk_sys);
        check(card_data_oe, 2'h3);
        host_drv_n = 2'h3;
        repeat (12) @(negedge clk_sys);
        check(card_data_oe, 2'h2);
        card_drv_n = 2'h2;
        repeat (8) @(negedge clk_sys);
        check(host_data_oe, 2'h1);
        card_drv_n = 2'h3;
        repeat (12) @(negedge clk_sys);
        check(host_data_oe, 2'h0);
        check(card_data_out | host_data_out, 2'h0);
        $display("test data path done");
        wr(8'h60, 7);
        check(card_power_en, 2'h3);
        wr(8'hbf, 8);
        check(card_power_en, 2'h3);
        check(card_volt_sel, 2'h1);
        check(card_clock_out, 2'h2);
        wr(8'h60, 8);
        check(card_power_en, 2'h0);
        check(card_reset_out | card_clock_out, 2'h0);
        check(card_data_oe, 2'h3);
        check(host_data_oe, 2'h0);
        $display("test refusals and power off done");
        summarize;
    end
endmodule // dss_top_tb
